/* hw/slc_dl_edge.sv */
`timescale 1ns/1ps
`default_nettype none

module slc_dl_edge (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic link_layer_active,
   output logic      dl_up_rise
);
   import slc_pkg::*;

   typedef struct packed {
      logic prev;
      logic rise;
   } slc_edge_st_t;

   slc_edge_st_t st;
   slc_edge_st_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // prev resets low, so a link already up after reset counts as an entry
   always_comb begin
      next_st      = st;
      next_st.prev = link_layer_active;
      next_st.rise = link_layer_active & ~st.prev;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dl_up_rise = st.rise;

endmodule

`default_nettype wire

/* hw/slc_msg_out.sv */
`timescale 1ns/1ps
`default_nettype none

module slc_msg_out (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                load,
   input  wire slc_pkg::slc_value_t value_in,
   input  wire slc_pkg::slc_scale_t scale_in,
   output slc_pkg::slc_value_t      msg_value,
   output slc_pkg::slc_scale_t      msg_scale
);
   import slc_pkg::*;

   typedef struct packed {
      slc_value_t value;
      slc_scale_t scale;
   } slc_msg_st_t;

   slc_msg_st_t st;
   slc_msg_st_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // payload frozen while a message is offered, even if software rewrites
   always_comb begin
      next_st = st;
      if (load) begin
         next_st.value = value_in;
         next_st.scale = scale_in;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign msg_value = st.value;
   assign msg_scale = st.scale;

endmodule

`default_nettype wire

/* hw/slc_pkg.sv */
package slc_pkg;

   typedef logic [7:0]  slc_value_t;
   typedef logic [12:0] slc_slot_num_t;

   // multiplier applied to the power limit value
   typedef enum logic [1:0] {
      SLC_SCALE_X1    = 2'h0,
      SLC_SCALE_XP1   = 2'h1,
      SLC_SCALE_XP01  = 2'h2,
      SLC_SCALE_XP001 = 2'h3
   } slc_scale_t;

   // gray ring: idle -> load -> send -> done -> idle
   typedef enum logic [1:0] {
      SLC_IDLE = 2'h0,
      SLC_LOAD = 2'h1,
      SLC_SEND = 2'h3,
      SLC_DONE = 2'h2
   } slc_state_t;

   // msb first, so the struct is bit for bit the register word
   typedef struct packed {
      slc_slot_num_t slot_num;
      logic          no_cmd_cpl;
      logic          interlock;
      slc_scale_t    scale;
      slc_value_t    value;
      logic          hotplug_capable;
      logic          surprise;
      logic          power_led;
      logic          attention_led;
      logic          latch_sensor;
      logic          power_ctrl;
      logic          button;
   } slc_caps_t;

endpackage

/* hw/slc_regs.svh */
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// register address
`define SLC_ADDR_W            12
`define SLC_SCAP_OFFSET       12'h054

////////////////////////////////////////////////////////////////////////////
// field positions of the slot capabilities word
`define SLC_BIT_BUTTON        0
`define SLC_BIT_POWER_CTRL    1
`define SLC_BIT_LATCH_SENSOR  2
`define SLC_BIT_ATTN_LED      3
`define SLC_BIT_POWER_LED     4
`define SLC_BIT_SURPRISE      5
`define SLC_BIT_HOTPLUG       6
`define SLC_LSB_PWR_VALUE     7
`define SLC_MSB_PWR_VALUE     14
`define SLC_LSB_PWR_SCALE     15
`define SLC_MSB_PWR_SCALE     16
`define SLC_BIT_INTERLOCK     17
`define SLC_BIT_NO_CMD_CPL    18
`define SLC_LSB_SLOT_NUM      19
`define SLC_MSB_SLOT_NUM      31

////////////////////////////////////////////////////////////////////////////
// access masks and reset values
`define SLC_LOCK_MASK         32'hFFFA007F
`define SLC_RW_MASK           32'h0001FF80
`define SLC_SCAP_RESET        32'h00000000
`define SLC_NO_CMD_CPL_VAL    1'h0
`define SLC_RDATA_IDLE        32'h00000000

`endif

/* hw/slc_slot_caps.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"

module slc_slot_caps (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic [`SLC_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   input  wire logic                   slot_implemented,
   input  wire logic                   cfg_lock_open,
   input  wire logic                   link_layer_active,
   output logic                        spl_msg_req,
   input  wire logic                   spl_msg_ack,
   output slc_pkg::slc_value_t         spl_msg_value,
   output slc_pkg::slc_scale_t         spl_msg_scale
);
   import slc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      slc_caps_t  caps;
      logic [31:0] rdata;
      slc_state_t state;
      logic       pending;
   } slc_top_st_t;

   slc_top_st_t st;
   slc_top_st_t next_st;

   logic        dl_up_rise;
   logic        scap_hit;
   logic        scap_write;
   logic        msg_trigger;
   logic        msg_load;
   logic [31:0] scap_view;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // one place decides whether an address names the capabilities word
   function automatic logic addr_is_scap(
      input logic [`SLC_ADDR_W-1:0] addr
   );
      addr_is_scap = (addr == `SLC_SCAP_OFFSET);
   endfunction

   // what software sees: zero everywhere while no slot is behind the port
   function automatic logic [31:0] visible_word(
      input slc_caps_t caps,
      input logic      slot_on
   );
      logic [31:0] word;
      word = caps;
      word[`SLC_BIT_NO_CMD_CPL] = `SLC_NO_CMD_CPL_VAL;
      if (!slot_on) begin
         word = '0;
      end
      visible_word = word;
   endfunction

   // merge a write under the two masks; bit 18 is in neither mask
   function automatic slc_caps_t merged_caps(
      input slc_caps_t   caps,
      input logic [31:0] wdata,
      input logic        lock_open
   );
      logic [31:0] mask;
      logic [31:0] word;
      mask = `SLC_RW_MASK;
      if (lock_open) begin
         mask = mask | `SLC_LOCK_MASK;
      end
      word = caps;
      word = (word & ~mask) | (wdata & mask);
      word[`SLC_BIT_NO_CMD_CPL] = `SLC_NO_CMD_CPL_VAL;
      merged_caps = word;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // link side: entry into DL_Up

   // link_layer_active high is the DL_Up condition
   slc_dl_edge u_dl_edge (
      .clk_sys           (clk_sys),
      .rst_n             (rst_n),
      .link_layer_active (link_layer_active),
      .dl_up_rise        (dl_up_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // register access

   assign scap_hit   = addr_is_scap(reg_addr);
   assign scap_write = reg_wr & scap_hit & slot_implemented;
   assign scap_view  = visible_word(st.caps, slot_implemented);

   // a write or a link coming up both ask for a fresh power limit message;
   // with no slot the limit is meaningless, so nothing is sent then
   assign msg_trigger = scap_write |
                        (dl_up_rise & slot_implemented);

   assign msg_load = (st.state == SLC_LOAD);

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st = st;

      // read data stands only in the cycle after the strobe
      next_st.rdata = `SLC_RDATA_IDLE;
      if (reg_rd && scap_hit) begin
         next_st.rdata = scap_view;
      end

      // button, power ctrl, latch, leds, surprise, hotplug, interlock,
      // slot number are lockable; value and scale are plain writable
      if (scap_write) begin
         next_st.caps = merged_caps(st.caps, reg_wdata,
                                    cfg_lock_open);
      end

      // a request that arrives while one is in flight is remembered, so
      // the partner ends up with the latest limit; set beats the clear
      if (msg_trigger) begin
         next_st.pending = 1'h1;
      end

      case (st.state)
         SLC_IDLE: begin
            if (st.pending) begin
               next_st.state = SLC_LOAD;
               if (!msg_trigger) begin
                  next_st.pending = 1'h0;
               end
            end
         end
         SLC_LOAD: begin
            // payload is copied in this cycle, so a write landing in the
            // same cycle is covered by the pending flag it just set
            next_st.state = SLC_SEND;
         end
         SLC_SEND: begin
            if (spl_msg_ack) begin
               next_st.state = SLC_DONE;
            end
         end
         SLC_DONE: begin
            next_st.state = SLC_IDLE;
         end
         default: begin
            next_st.state = SLC_IDLE;
         end
      endcase

      // the capability bits never hold a bit 18 value
      next_st.caps.no_cmd_cpl = `SLC_NO_CMD_CPL_VAL;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st.caps    <= `SLC_SCAP_RESET;
         st.rdata   <= `SLC_RDATA_IDLE;
         st.state   <= SLC_IDLE;
         st.pending <= 1'h0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // message payload

   // value and scale travel with the message exactly as programmed
   slc_msg_out u_msg_out (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .load      (msg_load),
      .value_in  (st.caps.value),
      .scale_in  (st.caps.scale),
      .msg_value (spl_msg_value),
      .msg_scale (spl_msg_scale)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign spl_msg_req = (st.state == SLC_SEND);
   assign reg_rdata   = st.rdata;

   // field map of the lockable presence flags:
   // button_present st.caps.button
   // surprise_removal st.caps.surprise
   // hotplug_capable st.caps.hotplug_capable
   // interlock_present st.caps.interlock
   // physical_slot_number st.caps.slot_num

endmodule

`default_nettype wire

/* tb/slc_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module slc_checker (
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   input wire logic [`SLC_ADDR_W-1:0] reg_addr,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [31:0]            reg_rdata,
   input wire logic                   slot_implemented,
   input wire logic                   link_layer_active,
   input wire logic                   spl_msg_req,
   input wire logic                   spl_msg_ack,
   input wire slc_pkg::slc_value_t    spl_msg_value,
   input wire slc_pkg::slc_scale_t    spl_msg_scale
);
   import slc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   sequence s_hit;
      reg_wr && slot_implemented && reg_addr == `SLC_SCAP_OFFSET;
   endsequence
   sequence s_gap;
      !spl_msg_req [*3];
   endsequence
   sequence s_quiet;
      (!slot_implemented && !spl_msg_req) [*5];
   endsequence
   ////////////////////////////////////////
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   a_bit18_zero: assert property (reg_rd |=> !reg_rdata[18])
      else $error("bit 18 not zero");
   a_noslot_read: assert property (
      reg_rd && !slot_implemented |=> reg_rdata == 32'h0)
      else $error("word not zero without slot");
   a_noslot_quiet: assert property (s_quiet |=> !spl_msg_req)
      else $error("message without slot");
   a_write_msg: assert property (s_hit |-> ##[1:8] spl_msg_req)
      else $error("no message after write");
   a_link_msg: assert property (
      $rose(link_layer_active) && slot_implemented |-> ##[1:8] spl_msg_req)
      else $error("no message after link up");
   a_req_hold: assert property (
      spl_msg_req && !spl_msg_ack |=> spl_msg_req && $stable(spl_msg_value)
      && $stable(spl_msg_scale))
      else $error("message dropped or changed");
   a_req_gap: assert property (spl_msg_req && spl_msg_ack |=> s_gap)
      else $error("message gap too short");
endmodule
bind slc_slot_caps slc_checker u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .slot_implemented(slot_implemented),
   .link_layer_active(link_layer_active), .spl_msg_req(spl_msg_req),
   .spl_msg_ack(spl_msg_ack), .spl_msg_value(spl_msg_value),
   .spl_msg_scale(spl_msg_scale));
`default_nettype wire

/* tb/slc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module slc_partner (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                slow,
   input  wire logic                spl_msg_req,
   input  wire slc_pkg::slc_value_t spl_msg_value,
   input  wire slc_pkg::slc_scale_t spl_msg_scale,
   output logic                     spl_msg_ack,
   output int                       n_msg,
   output slc_pkg::slc_value_t      got_value,
   output slc_pkg::slc_scale_t      got_scale
);
   import slc_pkg::*;
   int wait_cnt;
   ////////////////////////////////////////
   // a slow partner holds off the accept to stress the hold time
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         spl_msg_ack <= 1'b0;
         n_msg <= 0;
         wait_cnt <= 0;
         got_value <= 8'h00;
         got_scale <= SLC_SCALE_X1;
      end else if (spl_msg_req && spl_msg_ack) begin
         n_msg <= n_msg + 1;
         got_value <= spl_msg_value;
         got_scale <= spl_msg_scale;
         spl_msg_ack <= 1'b0;
         wait_cnt <= 0;
      end else begin
         wait_cnt <= spl_msg_req ? wait_cnt + 1 : 0;
         spl_msg_ack <= spl_msg_req && (!slow || wait_cnt >= 3);
      end
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.svh"
module testbench;
   import slc_pkg::*;
   logic                   clk_sys, rst_n, reg_wr, reg_rd, slow;
   logic                   slot, lock, link, spl_msg_req, spl_msg_ack;
   logic [`SLC_ADDR_W-1:0] reg_addr;
   logic [31:0]            reg_wdata, reg_rdata, model, d;
   slc_value_t             spl_msg_value, got_value;
   slc_scale_t             spl_msg_scale, got_scale;
   int                     num_errors, n_checks, n_msg, n_exp, cyc;
   localparam logic [11:0] OFF = `SLC_SCAP_OFFSET;

   slc_slot_caps dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_implemented(slot),
      .cfg_lock_open(lock), .link_layer_active(link),
      .spl_msg_req(spl_msg_req), .spl_msg_ack(spl_msg_ack),
      .spl_msg_value(spl_msg_value), .spl_msg_scale(spl_msg_scale));
   slc_partner u_far (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
      .spl_msg_req(spl_msg_req), .spl_msg_value(spl_msg_value),
      .spl_msg_scale(spl_msg_scale), .spl_msg_ack(spl_msg_ack),
      .n_msg(n_msg), .got_value(got_value), .got_scale(got_scale));
   ////////////////////////////////////////
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // write also updates the model word and the message count
   task wr(input logic [11:0] a, input logic [31:0] dat, input logic lk);
      logic [31:0] m;
      m = lk ? (`SLC_LOCK_MASK | `SLC_RW_MASK) : `SLC_RW_MASK;
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      lock <= lk;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      if (a == OFF && slot) begin
         model = (model & ~m) | (dat & m);
         n_exp++;
      end
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task msg_chk;
      for (int i = 0; i < 40 && n_msg != n_exp; i++) @(posedge clk_sys);
      repeat (6) @(posedge clk_sys);
      chk(n_msg, n_exp);
      chk({got_scale, got_value}, model[16:7]);
   endtask
   task link_up;
      @(posedge clk_sys) link <= 1'b0;
      repeat (3) @(posedge clk_sys);
      link <= 1'b1;
      if (slot) n_exp++;
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      void'($urandom(78));
      {rst_n, reg_wr, reg_rd, slow, link} = '0;
      {reg_addr, reg_wdata, model, cyc, n_exp} = '0;
      {slot, lock} = 2'b11;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk(OFF, 32'h0);
      for (int b = 0; b < 64; b++) begin
         wr(OFF, 32'h1 << (b % 32), b < 32);
         rd_chk(OFF, model);
         msg_chk;
      end
      // two writes close together must give two messages
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys) slow <= k[0];
         d = $urandom;
         wr(OFF, d, k[2]);
         d = $urandom;
         d[16:15] = k[1:0];
         wr(OFF, d, 1'b1);
         rd_chk(OFF, model);
         msg_chk;
      end
      link_up;
      msg_chk;
      wr(12'h058, 32'hFFFFFFFF, 1'b1);
      rd_chk(12'h058, 32'h0);
      rd_chk(OFF, model);
      @(posedge clk_sys) slot <= 1'b0;
      rd_chk(OFF, 32'h0);
      wr(OFF, $urandom, 1'b1);
      link_up;
      msg_chk;
      report_and_stop;
   end
endmodule
`default_nettype wire
